// ==== design/vrps_pkg.sv ====
// Constants for the power-up and strap sequencer
package vrps_pkg;
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PG_DELAY_NS = 5000;
  localparam int PG_DELAY_CYC = PG_DELAY_NS / CLK_PERIOD_NS;
  localparam int EN_WAIT_US = 8000;
  localparam int EN_WAIT_CYC = EN_WAIT_US * CLK_MHZ;
  localparam int INIT_CYC_DEF = 64;
  localparam int RAMP_STEP_CYC = 4;
  localparam int NVM_WORDS = 16;
  localparam int NVM_AW = 4;
  localparam logic [7:0] NVM_WORD_RST = 8'h00;
  localparam logic [9:0] VOUT_DEF_CODE = 10'h0A0;
  localparam logic [9:0] VOUT_MIN_TOL = 10'h096;
  localparam logic [9:0] VOUT_LSB_MV = 10'h005;
  localparam logic [9:0] TEMP_OFFSET_C = 10'h028;
  localparam logic [9:0] TEMP_MAX_C = 10'h096;
  localparam logic [9:0] CURRENT_MONITOR_FULL = 10'h3FF;
  localparam logic [3:0] PH_MAX_A = 4'h8;
  localparam logic [3:0] PH_MAX_B = 4'h2;
  localparam logic [1:0] STEP_NORMAL = 2'h2;
  localparam logic [1:0] STEP_QUIET = 2'h1;
  localparam logic [6:0] ADDR_MASK_HI = 7'h40;
  localparam logic WRITE_BIT = 1'b0;
  typedef enum {
    VRPS_OFF, VRPS_LOAD, VRPS_INIT, VRPS_IDLE, VRPS_RAMP, VRPS_RUN
  } vrps_state_t;
endpackage

// ==== design/vrps_telemetry.sv ====
// Telemetry code formatting for voltage, temperature and current
`timescale 1ns/1ps
`default_nettype none
module vrps_telemetry (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [9:0] vout_code,
  input wire logic signed [10:0] temp_c,
  input wire logic [10:0] current_monitor_a_raw,
  input wire logic [10:0] current_monitor_b_raw,
  output logic [9:0] vout_tel,
  output logic [9:0] temp_tel,
  output logic [9:0] current_monitor_a_tel,
  output logic [9:0] current_monitor_b_tel
);
  function automatic logic [9:0] sat10(input logic [10:0] v);
    sat10 = v[10] ? vrps_pkg::CURRENT_MONITOR_FULL : v[9:0];
  endfunction

  wire logic signed [10:0] temp_lo;
  wire logic signed [10:0] temp_hi;
  wire logic [9:0] temp_clamp;
  assign temp_lo = -$signed({1'b0, vrps_pkg::TEMP_OFFSET_C});
  assign temp_hi = $signed({1'b0, vrps_pkg::TEMP_MAX_C});
  // Range -40..150 C, two's complement code, 1 C per count
  assign temp_clamp = (temp_c < temp_lo) ? temp_lo[9:0] :
                      (temp_c > temp_hi) ? temp_hi[9:0] : temp_c[9:0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vout_tel <= 10'h000;
      temp_tel <= 10'h000;
      current_monitor_a_tel <= 10'h000;
      current_monitor_b_tel <= 10'h000;
    end else begin
      vout_tel <= vout_code;
      temp_tel <= temp_clamp;
      current_monitor_a_tel <= sat10(current_monitor_a_raw);
      current_monitor_b_tel <= sat10(current_monitor_b_raw);
    end
  end
endmodule
`default_nettype wire

// ==== design/vrps_sequencer.sv ====
// Power-up, strap latch and start-up sequencer
// Function
// - Copy stored configuration after memory threshold
// - Initialize with phase drives high impedance
// - Idle after init, ramp when enabled
// - Power good within 5us of tolerance
// - Configuration writes accepted only after init
// - Address strap selects one of sixteen
// - Eight-bit address is address plus write
// - Phase straps latched only during init
// - Pulled-up sense pin x limits rail A phases
// - Both first sense pins high disable rail
// - Noise pin reduces downward voltage step
// - Voltage telemetry 10 bits, 5mV LSB
// - Temperature telemetry 1C LSB, -40..150
// - Current code 1023 at full scale
// - Regulate only with reset done and enable
`timescale 1ns/1ps
`default_nettype none
module vrps_sequencer #(
  parameter int INIT_CYC = vrps_pkg::INIT_CYC_DEF,
  parameter int PG_CYC = vrps_pkg::PG_DELAY_CYC,
  parameter int RAMP_CYC = vrps_pkg::RAMP_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic memory_load_threshold,
  input wire logic por_main_ok,
  input wire logic rail_enable_in,
  input wire logic [3:0] addr_strap_code,
  input wire logic [7:0] phase_sense_pos_pin,
  input wire logic rail_a_first_sense_pos,
  input wire logic rail_a_first_sense_neg,
  input wire logic rail_b_first_sense_pos,
  input wire logic rail_b_first_sense_neg,
  input wire logic noise_suppress_enable_pin,
  input wire logic [7:0] nvm_rd_data,
  input wire logic cfg_wr_req,
  input wire logic [3:0] cfg_wr_addr,
  input wire logic [7:0] cfg_wr_data,
  input wire logic [9:0] vout_target,
  input wire logic signed [10:0] temp_c,
  input wire logic [10:0] current_monitor_a_raw,
  input wire logic [10:0] current_monitor_b_raw,
  output logic [3:0] nvm_rd_addr,
  output logic cfg_wr_ack,
  output logic [7:0] cfg_word_0,
  output logic load_done,
  output logic init_done,
  output logic regulate_en,
  output logic [9:0] phase_drive_out,
  output logic [9:0] phase_drive_oe,
  output logic power_good_out,
  output logic [6:0] i2c_addr7,
  output logic [7:0] i2c_addr8w,
  output logic [3:0] max_phase_a,
  output logic [3:0] max_phase_b,
  output logic rail_a_off,
  output logic rail_b_off,
  output logic [1:0] voltage_transition,
  output logic [9:0] vout_code,
  output logic [9:0] vout_tel,
  output logic [9:0] temp_tel,
  output logic [9:0] current_monitor_a_tel,
  output logic [9:0] current_monitor_b_tel
);
  vrps_pkg::vrps_state_t state_reg, state_next;
  logic [7:0] cfg_mem [vrps_pkg::NVM_WORDS];
  logic [3:0] ld_cnt_reg;
  logic [15:0] cnt_reg;
  logic [15:0] pg_cnt_reg;
  logic [3:0] ph_a_reg;
  logic [3:0] ph_b_reg;

  function automatic logic [3:0] phase_limit(input logic [7:0] pins,
                                            input logic [3:0] maxp);
    logic [3:0] lim;
    lim = maxp;
    for (int i = 7; i >= 1; i--) begin
      if (pins[i] && (4'(i - 1) < lim)) begin
        lim = 4'(i - 1);
      end
    end
    phase_limit = lim;
  endfunction

  wire logic in_init = (state_reg == vrps_pkg::VRPS_INIT);
  wire logic after_init = (state_reg == vrps_pkg::VRPS_IDLE) ||
                          (state_reg == vrps_pkg::VRPS_RAMP) ||
                          (state_reg == vrps_pkg::VRPS_RUN);
  wire logic run_ok = por_main_ok && rail_enable_in;
  wire logic ld_last = (ld_cnt_reg == 4'(vrps_pkg::NVM_WORDS - 1));
  wire logic cnt_done = (cnt_reg == 16'(INIT_CYC - 1));
  wire logic ramp_tick = (cnt_reg == 16'(RAMP_CYC - 1));
  wire logic at_target = (vout_code == vrps_pkg::VOUT_DEF_CODE);
  wire logic above_tol = (vout_code >= vrps_pkg::VOUT_MIN_TOL);
  wire logic [6:0] addr7 = vrps_pkg::ADDR_MASK_HI |
                           {1'b0, addr_strap_code[3:2], 2'b00,
                            addr_strap_code[1:0]};
  wire logic [1:0] step = noise_suppress_enable_pin ?
                          vrps_pkg::STEP_QUIET : vrps_pkg::STEP_NORMAL;
  wire logic down = vout_target < vout_code;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      vrps_pkg::VRPS_OFF: begin
        if (memory_load_threshold) begin
          state_next = vrps_pkg::VRPS_LOAD;
        end
      end
      vrps_pkg::VRPS_LOAD: begin
        if (ld_cnt_reg == 4'(vrps_pkg::NVM_WORDS - 1) && por_main_ok) begin
          state_next = vrps_pkg::VRPS_INIT;
        end
      end
      vrps_pkg::VRPS_INIT: begin
        if (cnt_done) begin
          state_next = vrps_pkg::VRPS_IDLE;
        end
      end
      vrps_pkg::VRPS_IDLE: begin
        if (run_ok && !(rail_a_off && rail_b_off)) begin
          state_next = vrps_pkg::VRPS_RAMP;
        end
      end
      vrps_pkg::VRPS_RAMP: begin
        if (!run_ok) begin
          state_next = vrps_pkg::VRPS_IDLE;
        end else if (at_target) begin
          state_next = vrps_pkg::VRPS_RUN;
        end
      end
      default: begin
        if (!run_ok) begin
          state_next = vrps_pkg::VRPS_IDLE;
        end
      end
    endcase
    if (!memory_load_threshold) begin
      state_next = vrps_pkg::VRPS_OFF;
    end else if (!por_main_ok && after_init) begin
      state_next = vrps_pkg::VRPS_INIT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= vrps_pkg::VRPS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || state_reg != vrps_pkg::VRPS_LOAD) begin
      ld_cnt_reg <= 4'h0;
    end else if (ld_cnt_reg != 4'(vrps_pkg::NVM_WORDS - 1)) begin
      ld_cnt_reg <= ld_cnt_reg + 4'h1;
    end
  end

  // One read per cycle; read data returns combinationally on nvm_rd_data
  always_ff @(posedge clk_sys) begin
    if (state_reg == vrps_pkg::VRPS_LOAD) begin
      cfg_mem[ld_cnt_reg] <= nvm_rd_data;
    end else if (cfg_wr_req && after_init) begin
      cfg_mem[cfg_wr_addr] <= cfg_wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg <= 16'h0000;
    end else if (state_reg != state_next || cnt_done ||
                 ramp_tick && (state_reg == vrps_pkg::VRPS_RAMP ||
                               state_reg == vrps_pkg::VRPS_RUN)) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ph_a_reg <= vrps_pkg::PH_MAX_A;
      ph_b_reg <= vrps_pkg::PH_MAX_B;
      rail_a_off <= 1'b0;
      rail_b_off <= 1'b0;
      i2c_addr7 <= vrps_pkg::ADDR_MASK_HI;
      i2c_addr8w <= {vrps_pkg::ADDR_MASK_HI, vrps_pkg::WRITE_BIT};
    end else if (in_init) begin
      ph_a_reg <= phase_limit(phase_sense_pos_pin,
                              vrps_pkg::PH_MAX_A);
      ph_b_reg <= vrps_pkg::PH_MAX_B;
      rail_a_off <= rail_a_first_sense_pos &&
                    rail_a_first_sense_neg;
      rail_b_off <= rail_b_first_sense_pos &&
                    rail_b_first_sense_neg;
      i2c_addr7 <= addr7;
      i2c_addr8w <= {addr7, vrps_pkg::WRITE_BIT};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vout_code <= 10'h000;
      voltage_transition <= 2'h0;
    end else if (state_reg == vrps_pkg::VRPS_RAMP && ramp_tick) begin
      vout_code <= vout_code + 10'h001;
      voltage_transition <= 2'h1;
    end else if (state_reg == vrps_pkg::VRPS_RUN && ramp_tick) begin
      if (down) begin
        vout_code <= (vout_code - vout_target < {8'h00, step}) ?
                     vout_target : vout_code - {8'h00, step};
        voltage_transition <= step;
      end else if (vout_target > vout_code) begin
        vout_code <= vout_code + 10'h001;
        voltage_transition <= 2'h1;
      end else begin
        voltage_transition <= 2'h0;
      end
    end else if (!after_init || state_reg == vrps_pkg::VRPS_IDLE) begin
      vout_code <= 10'h000;
      voltage_transition <= 2'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || !above_tol || !regulate_en) begin
      pg_cnt_reg <= 16'h0000;
      power_good_out <= 1'b0;
    end else if (pg_cnt_reg == 16'(PG_CYC - 2)) begin
      power_good_out <= 1'b1;
    end else begin
      pg_cnt_reg <= pg_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regulate_en <= 1'b0;
      phase_drive_oe <= 10'h000;
      phase_drive_out <= 10'h000;
      load_done <= 1'b0;
      init_done <= 1'b0;
      cfg_wr_ack <= 1'b0;
      nvm_rd_addr <= 4'h0;
      cfg_word_0 <= vrps_pkg::NVM_WORD_RST;
      max_phase_a <= vrps_pkg::PH_MAX_A;
      max_phase_b <= vrps_pkg::PH_MAX_B;
    end else begin
      regulate_en <= (state_next == vrps_pkg::VRPS_RAMP ||
                      state_next == vrps_pkg::VRPS_RUN);
      phase_drive_oe <= (state_next == vrps_pkg::VRPS_RAMP ||
                         state_next == vrps_pkg::VRPS_RUN) ?
                        10'h3FF : 10'h000;
      phase_drive_out <= 10'h000;
      load_done <= (state_reg != vrps_pkg::VRPS_OFF &&
                    state_reg != vrps_pkg::VRPS_LOAD);
      init_done <= after_init;
      cfg_wr_ack <= cfg_wr_req && after_init;
      // Hold the last word while the load waits for the main supply
      nvm_rd_addr <= (state_next != vrps_pkg::VRPS_LOAD ||
                      state_reg != vrps_pkg::VRPS_LOAD) ? 4'h0 :
                     ld_last ? ld_cnt_reg : ld_cnt_reg + 4'h1;
      cfg_word_0 <= cfg_mem[0];
      max_phase_a <= rail_a_off ? 4'h0 : ph_a_reg;
      max_phase_b <= rail_b_off ? 4'h0 : ph_b_reg;
    end
  end

  vrps_telemetry u_tel (
    .clk_sys(clk_sys),
    .srst(srst),
    .vout_code(vout_code),
    .temp_c(temp_c),
    .current_monitor_a_raw(current_monitor_a_raw),
    .current_monitor_b_raw(current_monitor_b_raw),
    .vout_tel(vout_tel),
    .temp_tel(temp_tel),
    .current_monitor_a_tel(current_monitor_a_tel),
    .current_monitor_b_tel(current_monitor_b_tel)
  );

  chk_init_hiz: assert property (@(posedge clk_sys) disable iff (srst)
    in_init |=> phase_drive_oe == 10'h000)
    else $error("phase drive enabled during init");
  chk_reg_gate: assert property (@(posedge clk_sys) disable iff (srst)
    regulate_en |-> $past(por_main_ok) && $past(rail_enable_in))
    else $error("regulation without enable");
  chk_pg_delay: assert property (@(posedge clk_sys) disable iff (srst)
    (above_tol && regulate_en)[*8] |-> ##[0:700] power_good_out)
    else $error("power good late");
  chk_wr_block: assert property (@(posedge clk_sys) disable iff (srst)
    cfg_wr_ack |-> $past(after_init))
    else $error("config write acked before init");
  chk_strap_hold: assert property (@(posedge clk_sys) disable iff (srst)
    $past(after_init) && after_init |-> $stable(i2c_addr7) &&
    $stable(ph_a_reg))
    else $error("straps changed after init");
  chk_addr_fmt: assert property (@(posedge clk_sys) disable iff (srst)
    i2c_addr8w == {i2c_addr7, 1'b0})
    else $error("8-bit address mismatch");
  chk_early_en: assert property (@(posedge clk_sys) disable iff (srst)
    !after_init |=> !regulate_en)
    else $error("ramp before init end");
  chk_load_first: assert property (@(posedge clk_sys) disable iff (srst)
    state_reg == vrps_pkg::VRPS_LOAD && memory_load_threshold
    |=> state_reg inside {vrps_pkg::VRPS_LOAD, vrps_pkg::VRPS_INIT})
    else $error("load sequence skipped");
endmodule
`default_nettype wire

// ==== verification/vrps_host_model.sv ====
// Rail enable side of the system power sequencing logic
`timescale 1ns/1ps
`default_nettype none
module vrps_host_model #(
  parameter int WAIT_CYC = 40
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic por_main_ok,
  input wire logic go,
  input wire logic early,
  output logic rail_enable_in
);
  int wait_reg;
  always_ff @(posedge clk_sys) begin
    if (srst || !por_main_ok) begin
      wait_reg <= 0;
    end else if (wait_reg < WAIT_CYC) begin
      wait_reg <= wait_reg + 1;
    end
  end
  // Early raises the enable before the settle wait, only when asked
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rail_enable_in <= 1'b0;
    end else begin
      rail_enable_in <= go && (early || wait_reg >= WAIT_CYC);
    end
  end
endmodule
`default_nettype wire

// ==== verification/vrps_sequencer_tb.sv ====
// Self-checking bench for the power-up and strap sequencer
`timescale 1ns/1ps
`default_nettype none
module vrps_sequencer_tb;
  localparam int INIT = 16;
  localparam int PG = 10;
  typedef struct {int kind; logic [9:0] val;} vrps_note_t;
  logic clk_sys, srst, memory_load_threshold, por_main_ok, rail_enable_in;
  logic [3:0] addr_strap_code, cfg_wr_addr, nvm_rd_addr;
  logic [3:0] max_phase_a, max_phase_b;
  logic [7:0] phase_sense_pos_pin, cfg_wr_data, cfg_word_0, i2c_addr8w;
  logic rail_a_first_sense_pos, rail_a_first_sense_neg;
  logic rail_b_first_sense_pos, rail_b_first_sense_neg;
  logic noise_suppress_enable_pin, cfg_wr_req, cfg_wr_ack, load_done;
  logic init_done, regulate_en, power_good_out, rail_a_off, rail_b_off;
  logic go, early, in_tol, at_def;
  logic [9:0] vout_target, phase_drive_out, phase_drive_oe, vout_code;
  logic [9:0] vout_tel, temp_tel, current_monitor_a_tel, current_monitor_b_tel, e;
  logic signed [10:0] temp_c;
  logic [10:0] current_monitor_a_raw, current_monitor_b_raw;
  logic [6:0] i2c_addr7;
  logic [1:0] voltage_transition;
  wire logic [7:0] nvm_rd_data;
  int err_count, samples_checked, i, t, b;
  logic [31:0] seed = 32'h4DD7;
  logic [31:0] r;
  vrps_note_t exp_q[$];
  // Stored image: word n reads back as 0x50 + n
  assign nvm_rd_data = {4'h5, nvm_rd_addr};
  always @* in_tol = vout_code >= vrps_pkg::VOUT_MIN_TOL;
  always @* at_def = vout_code == vrps_pkg::VOUT_DEF_CODE;
  vrps_sequencer #(.INIT_CYC(INIT), .PG_CYC(PG)) u_vrps_sequencer (
    .clk_sys, .srst, .memory_load_threshold, .por_main_ok, .rail_enable_in,
    .addr_strap_code, .phase_sense_pos_pin, .rail_a_first_sense_pos,
    .rail_a_first_sense_neg, .rail_b_first_sense_pos, .rail_b_first_sense_neg,
    .noise_suppress_enable_pin, .nvm_rd_data, .cfg_wr_req, .cfg_wr_addr,
    .cfg_wr_data, .vout_target, .temp_c, .current_monitor_a_raw, .current_monitor_b_raw,
    .nvm_rd_addr, .cfg_wr_ack, .cfg_word_0, .load_done, .init_done,
    .regulate_en, .phase_drive_out, .phase_drive_oe, .power_good_out,
    .i2c_addr7, .i2c_addr8w, .max_phase_a, .max_phase_b, .rail_a_off,
    .rail_b_off, .voltage_transition, .vout_code, .vout_tel, .temp_tel,
    .current_monitor_a_tel, .current_monitor_b_tel);
  vrps_host_model #(.WAIT_CYC(40)) u_vrps_host_model (
    .clk_sys, .srst, .por_main_ok, .go, .early, .rail_enable_in);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] obs(input int k);
    case (k)
      0: return 10'(i2c_addr7);
      1: return 10'(i2c_addr8w);
      2: return 10'(max_phase_a);
      3: return 10'(max_phase_b);
      4: return 10'(rail_a_off);
      5: return 10'(rail_b_off);
      6: return phase_drive_oe;
      7: return 10'(power_good_out);
      8: return vout_code;
      9: return vout_tel;
      10: return temp_tel;
      11: return current_monitor_a_tel;
      12: return current_monitor_b_tel;
      13: return 10'(cfg_wr_ack);
      14: return 10'(cfg_word_0);
      15: return 10'(regulate_en);
      16: return 10'(voltage_transition);
      17: return 10'(load_done);
      default: return phase_drive_out;
    endcase
  endfunction
  task automatic note(input int k, input logic [9:0] v);
    exp_q.push_back('{k, v});
  endtask
  task automatic check_val(input int k, input logic [9:0] ex, got);
    samples_checked++;
    if (got !== ex) begin
      err_count++;
      $display("FAIL t=%0t kind %0d exp %h got %h", $time, k, ex, got);
    end
  endtask
  // Monitor drains the notes once the outputs have settled
  always @(negedge clk_sys) begin
    #1;
    while (exp_q.size() > 0) begin
      check_val(exp_q[0].kind, exp_q[0].val, obs(exp_q[0].kind));
      void'(exp_q.pop_front());
    end
  end
  task automatic close_out();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_until(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      $display("FAIL t=%0t wait ran out", $time);
    end
  endtask
  // Full supply cycle; a refused early write is tried along the way
  task automatic boot(input logic [3:0] idx, input logic [7:0] ph);
    memory_load_threshold = 1'b0;
    por_main_ok = 1'b0;
    repeat (2) @(negedge clk_sys);
    addr_strap_code = idx;
    phase_sense_pos_pin = ph;
    memory_load_threshold = 1'b1;
    por_main_ok = 1'b1;
    @(negedge clk_sys);
    cfg_wr_req = 1'b1;
    @(negedge clk_sys);
    cfg_wr_req = 1'b0;
    note(13, 10'h000);
    note(6, 10'h000);
    note(15, 10'h000);
    wait_until(init_done, 200);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("FAIL t=%0t run hung", $time);
    close_out();
  end
  initial begin
    srst = 1'b1;
    {memory_load_threshold, por_main_ok, go, early, cfg_wr_req} = 5'h00;
    {rail_a_first_sense_pos, rail_a_first_sense_neg} = 2'h0;
    {rail_b_first_sense_pos, rail_b_first_sense_neg} = 2'h0;
    noise_suppress_enable_pin = 1'b0;
    {addr_strap_code, cfg_wr_addr, phase_sense_pos_pin} = 16'h0000;
    cfg_wr_data = 8'hFF;
    vout_target = vrps_pkg::VOUT_DEF_CODE;
    temp_c = 11'h000;
    {current_monitor_a_raw, current_monitor_b_raw} = 22'h000000;
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    note(0, 10'h040);
    note(1, 10'h080);
    note(2, 10'h008);
    for (i = 0; i < 16; i++) begin
      b = 2 + rnd() % 6;
      e = (i % 4 == 0) ? 10'h008 : 10'(b - 1);
      r = rnd();
      {rail_a_first_sense_pos, rail_a_first_sense_neg} = r[1:0];
      {rail_b_first_sense_pos, rail_b_first_sense_neg} = r[3:2];
      boot(i[3:0], (i % 4 == 0) ? 8'h00 : 8'(1 << b));
      note(0, 10'(7'h40 | {i[3:2], 2'b00, i[1:0]}));
      note(1, 10'({7'h40 | {i[3:2], 2'b00, i[1:0]}, 1'b0}));
      note(2, (r[0] & r[1]) ? 10'h000 : e);
      note(3, (r[2] & r[3]) ? 10'h000 : 10'h002);
      note(4, 10'(r[0] & r[1]));
      note(5, 10'(r[2] & r[3]));
      note(14, 10'h050);
      note(17, 10'h001);
      phase_sense_pos_pin = 8'h02;
      repeat (3) @(negedge clk_sys);
      note(2, (r[0] & r[1]) ? 10'h000 : e);
    end
    {rail_a_first_sense_pos, rail_a_first_sense_neg} = 2'h0;
    {rail_b_first_sense_pos, rail_b_first_sense_neg} = 2'h0;
    go = 1'b1;
    early = 1'b1;
    boot(4'h0, 8'h00);
    cfg_wr_data = 8'(rnd());
    cfg_wr_req = 1'b1;
    @(negedge clk_sys);
    cfg_wr_req = 1'b0;
    note(13, 10'h001);
    @(negedge clk_sys);
    note(14, 10'(cfg_wr_data));
    wait_until(in_tol, 2000);
    repeat (PG + 1) @(negedge clk_sys);
    note(7, 10'h001);
    note(15, 10'h001);
    note(6, 10'h3FF);
    note(18, 10'h000);
    wait_until(at_def, 200);
    @(negedge clk_sys);
    note(8, vrps_pkg::VOUT_DEF_CODE);
    note(9, vrps_pkg::VOUT_DEF_CODE);
    for (i = 0; i < 8; i++) begin
      t = int'(rnd() % 211) - 50;
      r = rnd();
      temp_c = 11'(t);
      current_monitor_a_raw = r[10:0];
      current_monitor_b_raw = r[21:11];
      repeat (2) @(negedge clk_sys);
      e = 10'(t < -40 ? -40 : (t > 150 ? 150 : t));
      note(10, e);
      note(11, r[10] ? 10'h3FF : r[9:0]);
      note(12, r[21] ? 10'h3FF : r[20:11]);
    end
    noise_suppress_enable_pin = 1'b1;
    vout_target = 10'h050;
    repeat (8) @(negedge clk_sys);
    note(16, 10'(vrps_pkg::STEP_QUIET));
    noise_suppress_enable_pin = 1'b0;
    repeat (8) @(negedge clk_sys);
    note(16, 10'(vrps_pkg::STEP_NORMAL));
    go = 1'b0;
    repeat (3) @(negedge clk_sys);
    note(7, 10'h000);
    note(15, 10'h000);
    @(negedge clk_sys);
    #2;
    close_out();
  end
endmodule
`default_nettype wire
